// *** hdl/sjtap_tap.sv ***
// test access port controller with instruction, bypass, id, scan registers
`timescale 1ns/100ps
module sjtap_tap
    import sjtap_pkg::*;
#(
    parameter logic [31:0] ID_CODE = 32'h1234_5671 // arbitrary value
) (
    input wire logic ref_clk_i,              // core clock 25 MHz
    input wire logic resetn_i,               // async reset, active low
    input wire logic tck_i,                  // test clock pin
    input wire logic tms_i,                  // mode select pin
    input wire logic tdi_i,                  // serial data in pin
    input wire logic [sjtap_pkg::BSR_W-1:0] pins_i, // i/o ring levels
    output logic tdo_o,                      // serial data out
    output logic tdo_oe_o,                   // serial out enable
    output logic [sjtap_pkg::BSR_W-1:0] pins_o, // scan drive values
    output logic pins_take_o,                // scan owns functional pins
    output logic q_float_o,                  // force data outputs off
    output logic [3:0] state_o               // controller state
);
    import sjtap_pkg::*;
    logic tck_s, tms_s, tdi_s, tck_d;
    logic rise, fall;
    sjtap_state_t state, next_state;
    logic [IR_W-1:0] ir_sh, ir;
    logic byp;
    logic [ID_W-1:0] id_sh;
    logic [BSR_W-1:0] bsr_sh;
    logic [BSR_W-1:0] pins_s;
    logic serial;

    sjtap_sync u_tck (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .d_i(tck_i), .rst_val_i(1'b0), .q_o(tck_s));
    sjtap_sync u_tms (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .d_i(tms_i), .rst_val_i(1'b1), .q_o(tms_s));
    sjtap_sync u_tdi (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .d_i(tdi_i), .rst_val_i(1'b1), .q_o(tdi_s));

    // ring levels come from pins, so each bit is synchronised first
    for (genvar gi = 0; gi < BSR_W; gi++) begin : g_pin_sync
        sjtap_sync u_pin (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
            .d_i(pins_i[gi]), .rst_val_i(1'b0), .q_o(pins_s[gi]));
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end
    assign rise = tck_s & ~tck_d;
    assign fall = ~tck_s & tck_d;

    // standard graph; five high edges reach reset from anywhere
    always_comb begin
        next_state = state;
        unique case (state)
            ST_RESET: next_state = tms_s ? ST_RESET : ST_IDLE;
            ST_IDLE: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = tms_s ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: next_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: next_state = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: next_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: next_state = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = tms_s ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: next_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: next_state = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: next_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: next_state = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: next_state = tms_s ? ST_SEL_DR : ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_RESET;
        end else if (rise) begin
            state <= next_state;
        end
    end

    // instruction shift and active instruction
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ir_sh <= IR_RESET;
            ir <= IR_RESET;
        end else if (rise) begin
            unique case (state)
                ST_RESET: begin
                    ir_sh <= IR_RESET;
                    ir <= IR_RESET;
                end
                ST_CAP_IR: ir_sh <= IR_RESET;
                ST_SHIFT_IR: ir_sh <= {tdi_s, ir_sh[IR_W-1:1]};
                ST_UPD_IR: ir <= ir_sh;
                default: ir_sh <= ir_sh;
            endcase
        end
    end

    // data registers: capture in Capture-DR, shift in Shift-DR
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            byp <= 1'b0;
            id_sh <= '0;
            bsr_sh <= '0;
        end else if (rise && state == ST_CAP_DR) begin
            byp <= 1'b0;
            id_sh <= ID_CODE;
            bsr_sh <= pins_s;
        end else if (rise && state == ST_SHIFT_DR) begin
            unique case (ir)
                INS_BYPASS: byp <= tdi_s;
                INS_IDENT: id_sh <= {tdi_s, id_sh[ID_W-1:1]};
                INS_EXTEST, INS_FLOAT, INS_SAMPLE:
                    bsr_sh <= {tdi_s, bsr_sh[BSR_W-1:1]};
                default: byp <= tdi_s; // reserved codes act as bypass
            endcase
        end
    end

    always_comb begin
        serial = byp;
        if (state == ST_SHIFT_IR) begin
            serial = ir_sh[0];
        end else if (ir == INS_IDENT) begin
            serial = id_sh[0];
        end else if (ir == INS_EXTEST || ir == INS_FLOAT ||
                     ir == INS_SAMPLE) begin
            serial = bsr_sh[0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (fall) begin
            tdo_o <= serial;
            tdo_oe_o <= (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pins_o <= '0;
            pins_take_o <= 1'b0;
            q_float_o <= 1'b0;
            state_o <= 4'h0;
        end else begin
            if (rise && state == ST_UPD_DR && ir == INS_EXTEST) begin
                pins_o <= bsr_sh;
            end
            pins_take_o <= (ir == INS_EXTEST) || (ir == INS_FLOAT);
            q_float_o <= (ir == INS_FLOAT);
            state_o <= state;
        end
    end

    // assertions
    int unsigned high_cnt;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            high_cnt <= 0;
        end else if (rise) begin
            high_cnt <= tms_s ? ((high_cnt < RESET_HIGH_EDGES) ?
                high_cnt + 1 : RESET_HIGH_EDGES) : 0;
        end
    end

    property p_five_high;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (high_cnt >= RESET_HIGH_EDGES) |-> state == ST_RESET;
    endproperty
    a_five_high: assert property (p_five_high) else $error("no reset");

    property p_hold;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !$past(rise) |-> $stable(state);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved");

    property p_oe;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(tdo_oe_o) |-> $past(state == ST_SHIFT_IR || state == ST_SHIFT_DR);
    endproperty
    a_oe: assert property (p_oe) else $error("oe outside shift");

    property p_tdo_fall;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !$past(fall) |-> $stable(tdo_o);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved");

    property p_ir_reset;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        $past(rise) && $past(state) == ST_RESET |-> ir == IR_RESET;
    endproperty
    a_ir_reset: assert property (p_ir_reset) else $error("ir preset");

    property p_ir_upd;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        !($past(rise) && $past(state) inside {ST_UPD_IR, ST_RESET})
            |-> $stable(ir);
    endproperty
    a_ir_upd: assert property (p_ir_upd) else $error("ir early");

    sequence s_cap_dr;
        rise && state == ST_CAP_DR;
    endsequence
    property p_byp;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        s_cap_dr ##1 1'b1 |-> byp == 1'b0;
    endproperty
    a_byp: assert property (p_byp) else $error("bypass not zero");

    property p_ir_shift;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        rise && state == ST_SHIFT_IR |=> ir_sh[IR_W-1] == $past(tdi_s);
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("ir shift");

    property p_take;
        @(posedge ref_clk_i) disable iff (!resetn_i)
        (ir == INS_SAMPLE || ir == INS_BYPASS || ir == INS_IDENT)
            ##1 $stable(ir) |-> !pins_take_o;
    endproperty
    a_take: assert property (p_take) else $error("pins taken");
endmodule : sjtap_tap

// *** hdl/sjtap_pkg.sv ***
// package of state, instruction and register constants for the test port
package sjtap_pkg;
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } sjtap_state_t;
    localparam int IR_W = 3;
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDENT = 3'h1;
    localparam logic [2:0] INS_FLOAT = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [2:0] IR_RESET = INS_IDENT;
    localparam int ID_W = 32;
    localparam int BSR_W = 16;
    localparam int RESET_HIGH_EDGES = 5;
endpackage : sjtap_pkg

// *** hdl/sjtap_sync.sv ***
// two-flop synchroniser for one pin input
`timescale 1ns/100ps
module sjtap_sync (
    input wire logic ref_clk_i, // core clock
    input wire logic resetn_i,  // async reset, active low
    input wire logic d_i,       // asynchronous input
    input wire logic rst_val_i, // level meant for reset (unused; reset loads 0)
    output logic q_o            // synchronised level
);
    logic meta;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
    logic unused;
    assign unused = rst_val_i;
endmodule : sjtap_sync

// *** dv/sjtap_tester.sv ***
// tester model that drives the test port pins
`timescale 1ns/100ps
module sjtap_tester (
    output logic tck_o,       // test clock, low between frames
    output logic tms_o,       // mode select
    output logic tdi_o,       // serial data to the port
    input wire logic tdo_i,   // serial data from the port
    input wire logic tdo_oe_i // port drives serial out
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // one 320 ns test clock period; serial out is taken at the rise
    task automatic step(input logic tms, input logic tdi,
        output logic tdo, output logic oe);
        tms_o = tms;
        tdi_o = tdi;
        #80;
        oe = tdo_oe_i;
        // a released serial out shows the inverse of its last level
        tdo = tdo_oe_i ? tdo_i : ~tdo_i;
        tck_o = 1'b1;
        #120;
        // flip data once the rise is taken, so a late resample shows up
        tdi_o = ~tdi;
        #40;
        tck_o = 1'b0;
        #80;
    endtask : step
endmodule : sjtap_tester

// *** dv/tb.sv ***
// testbench for the test access port
`timescale 1ns/100ps
module tb;
    import sjtap_pkg::*;
    localparam logic [31:0] ID_VAL = 32'h5a5a_0f01; // arbitrary value
    logic ref_clk_i, resetn_i, tck, tms, tdi, tdo_o, tdo_oe_o;
    logic pins_take_o, q_float_o, so, soe;
    logic [BSR_W-1:0] pins_i, pins_o;
    logic [3:0] state_o;
    logic [31:0] got;
    int n_fail = 0, checked = 0, cyc = 0;
    sjtap_tap #(.ID_CODE(ID_VAL)) u_sjtap_tap (.ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .pins_i(pins_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
        .pins_o(pins_o), .pins_take_o(pins_take_o),
        .q_float_o(q_float_o), .state_o(state_o));
    sjtap_tester u_sjtap_tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        if (n_fail == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : close_out
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic st(input logic m, input logic d);
        u_sjtap_tester.step(m, d, so, soe);
    endtask : st
    // from idle: shift n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n, input logic [31:0] d);
        logic pt;
        pt = pins_take_o;
        st(1'b1, 1'b1);
        if (ir) st(1'b1, 1'b1);
        st(1'b0, 1'b1);
        st(1'b0, 1'b1);
        got = '0;
        for (int i = 0; i < n; i++) begin
            st(i == n - 1, d[i]);
            got[i] = so;
            chk(soe, 1'b1);
        end
        chk(pins_take_o, pt);
        st(1'b1, 1'b1);
        chk(soe, 1'b0);
        st(1'b0, 1'b1);
    endtask : scan
    task automatic walk();
        logic m [20] = '{1,0,1,0,0,1,0,1,0,1,1,1,1,0,0,1,0,1,1,0};
        logic [3:0] e [20] = '{0,1,2,3,4,5,6,7,4,5,8,2,9,10,11,12,13,14,15,1};
        for (int i = 0; i < 20; i++) begin
            st(m[i], 1'b1);
            chk(state_o, e[i]);
        end
    endtask : walk
    task automatic five_high();
        st(1'b1, 1'b0);
        st(1'b0, 1'b0);
        st(1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            st(1'b1, 1'b0);
            if (i == 3) chk(state_o, 4'h9);
        end
        chk(state_o, 4'h0);
        st(1'b0, 1'b1);
    endtask : five_high
    task automatic instr_pins();
        logic [2:0] c [4] = '{3'h0, 3'h2, 3'h4, 3'h1};
        logic t [4] = '{1, 1, 0, 0};
        logic f [4] = '{0, 1, 0, 0};
        for (int i = 0; i < 4; i++) begin
            scan(1'b1, 3, {29'h0, c[i]});
            chk(pins_take_o, t[i]);
            chk(q_float_o, f[i]);
        end
    endtask : instr_pins
    task automatic bypass_codes();
        logic [2:0] c [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
        for (int i = 0; i < 4; i++) begin
            scan(1'b1, 3, {29'h0, c[i]});
            scan(1'b0, 4, 32'hb);
            chk(got, 32'h6);
        end
    endtask : bypass_codes
    task automatic ring_scan();
        @(posedge ref_clk_i);
        #1 pins_i = 16'hc3a5;
        scan(1'b1, 3, 32'h4);
        scan(1'b0, 16, 32'h5a0f);
        chk(got, 32'hc3a5);
        chk(pins_o, 16'h0);
        scan(1'b1, 3, 32'h0);
        scan(1'b0, 16, 32'h5a0f);
        chk(pins_o, 16'h5a0f);
    endtask : ring_scan
    initial begin
        resetn_i = 1'b0;
        pins_i = '0;
        repeat (3) @(posedge ref_clk_i);
        #1 resetn_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk(state_o, 4'h0);
        chk(tdo_oe_o, 1'b0);
        walk();
        scan(1'b1, 3, 32'h7);
        chk(got, 32'h1);
        bypass_codes();
        instr_pins();
        ring_scan();
        five_high();
        scan(1'b0, 32, 32'h0);
        chk(got, ID_VAL);
        close_out();
    end
endmodule : tb
